// ### hdl/vdrc_top.sv
/*
 * Routing and format configuration registers of the video datapath.
 * Assumes host port and vblank_i on the system clock.
 */
// Functional notes
// - Input format code sets input formatter clock frequencies for both input ports.
// - Output-input-type bit: 0 true full-chroma, 1 pseudo full-chroma.
// - Output format 0011-0101 two buses 4:2:2, 0110-1000 three buses 4:4:4.
// - Parallel output enable bit drives or disables the parallel output while output format is 0011-1000, else output stays disabled.
// - Parallel output source: eight codes, primary input through overlay blend 2.
// - Each transmitter has its own source field, same eight-code encoding.
// - Gating bit set routes SD encoder source onto HD encoder path.
// - Secondary scaler source uses codes 0x00 through 0x06.
// - Primary scaler source uses codes 0x00 through 0x05.
// - Interlacer source uses codes 0x00 through 0x04.
// - Both overlay blender sources use codes 0x00 through 0x04.
// - Horizontal prescaler source uses codes 0x00 through 0x03.
// - Bypass bit set skips serial receive input processing.
// - Secondary channel select: 00 video, 01 overlay input, 10 receive; 11 unused.
// - Primary channel select: 00 video, 01 overlay, 10 combined 48-bit; 11 reserved.
// - Audio mode: 00 single, 01/10/11 dual with I2S or S/PDIF per transmitter.
// - Dither level 00 smooth to 11 sharp; alpha gains high-frequency part.
// - 12-bit pixel and 16-bit sum thresholds set dither frequency split.
// - Slave and master serial ports each have polarity and phase bits.
// - Buffer bit 0 applies adjust enables at once, 1 only in vblank.
// - Saturation enable bit switches saturation adjustment on or off.
// - Brightness enable bit switches brightness adjustment on or off.
`timescale 1ns/100ps
`include "vdrc_defs.svh"

module vdrc_top
    import vdrc_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // Host control port
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [15:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_rvalid_o,
    // Video timing
    input wire logic vblank_i,
    // Input formatting
    output logic [7:0] input_format_code_o,
    output vdrc_chan_t prim_chan_o,
    output vdrc_chan_t sec_chan_o,
    output logic rx_proc_bypass_o,
    // Parallel output
    output vdrc_pofmt_t parallel_out_bus_format_o,
    output vdrc_src_t parallel_out_source_o,
    // Transmitters and encoders
    output vdrc_src_t transmitter1_source_o,
    output vdrc_src_t transmitter2_source_o,
    output vdrc_src_t high_def_encoder_source_o,
    output vdrc_src_t std_def_encoder_source_o,
    // Processing engines
    output vdrc_src_t prim_scaler_engine_source_o,
    output vdrc_src_t sec_scaler_engine_source_o,
    output vdrc_src_t interlacer_source_o,
    output vdrc_src_t blend1_source_o,
    output vdrc_src_t blend2_source_o,
    output vdrc_src_t prescaler_source_o,
    // Audio, dither, serial port, video adjust
    output vdrc_audio_t audio_mode_o,
    output vdrc_dither_t dither_o,
    output vdrc_spi_t spi_clocking_o,
    output vdrc_adj_t video_adjust_o
);

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic rst_meta_q;
    logic rst_sync_q;

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Reserved codes are flagged so the consumer is parked rather than
    // steered onto an undefined path.
    function automatic vdrc_src_t src_check(input logic [3:0] code, input logic [3:0] max_code);
        vdrc_src_t r;
        r.valid = (code <= max_code);
        r.code = r.valid ? code : 4'h0;
        return r;
    endfunction

    function automatic vdrc_chan_t chan_check(input logic [1:0] code, input logic [1:0] max_code);
        vdrc_chan_t r;
        r.valid = (code <= max_code);
        r.code = r.valid ? code : 2'h0;
        return r;
    endfunction

    // ------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------
    logic [7:0] infmt_q;
    logic [7:0] potype_q;
    logic [7:0] poctrl_q;
    logic [7:0] txsel_q;
    logic [7:0] encsel_q;
    logic [7:0] sclsel_q;
    logic [7:0] cnvsel_q;
    logic [7:0] chctrl_q;
    logic [7:0] audsel_q;
    logic [7:0] hpssel_q;
    logic [7:0] dith_q;
    logic [7:0] pixhi_q;
    logic [7:0] pixlo_q;
    logic [7:0] sumhi_q;
    logic [7:0] sumlo_q;
    logic [7:0] spi_q;
    logic [7:0] vadj_q;

    // Reserved bits are not stored and read back as zero, except VADJ bits 4:0, which are stored as written (reset sets bit 0),
    // and POTYPE bit 1 and CHCTRL bit 5, which reset loads as one until written.
    always_ff @(posedge sys_clk_i or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            infmt_q <= `VDRC_RST_INFMT;
            potype_q <= `VDRC_RST_POTYPE;
            poctrl_q <= `VDRC_RST_POCTRL;
            txsel_q <= `VDRC_RST_TXSEL;
            encsel_q <= `VDRC_RST_ENCSEL;
            sclsel_q <= `VDRC_RST_SCLSEL;
            cnvsel_q <= `VDRC_RST_CNVSEL;
            chctrl_q <= `VDRC_RST_CHCTRL;
            audsel_q <= `VDRC_RST_AUDSEL;
            hpssel_q <= `VDRC_RST_HPSSEL;
            dith_q <= `VDRC_RST_DITH;
            pixhi_q <= `VDRC_RST_PIXHI;
            pixlo_q <= `VDRC_RST_PIXLO;
            sumhi_q <= `VDRC_RST_SUMHI;
            sumlo_q <= `VDRC_RST_SUMLO;
            spi_q <= `VDRC_RST_SPI;
            vadj_q <= `VDRC_RST_VADJ;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                `VDRC_OFS_INFMT: infmt_q <= reg_wdata_i;
                `VDRC_OFS_POTYPE: potype_q <= {7'h00, reg_wdata_i[0]};
                `VDRC_OFS_POCTRL: poctrl_q <= reg_wdata_i;
                `VDRC_OFS_TXSEL: txsel_q <= reg_wdata_i;
                `VDRC_OFS_ENCSEL: encsel_q <= reg_wdata_i;
                `VDRC_OFS_SCLSEL: sclsel_q <= reg_wdata_i;
                `VDRC_OFS_CNVSEL: cnvsel_q <= reg_wdata_i;
                `VDRC_OFS_CHCTRL: chctrl_q <= {reg_wdata_i[7:6], 2'h0, reg_wdata_i[3:0]};
                `VDRC_OFS_AUDSEL: audsel_q <= {reg_wdata_i[7:6], 2'h0, reg_wdata_i[3:0]};
                `VDRC_OFS_HPSSEL: hpssel_q <= {reg_wdata_i[7:4], 4'h0};
                `VDRC_OFS_DITH: dith_q <= {2'h0, reg_wdata_i[5:0]};
                `VDRC_OFS_PIXHI: pixhi_q <= {4'h0, reg_wdata_i[3:0]};
                `VDRC_OFS_PIXLO: pixlo_q <= reg_wdata_i;
                `VDRC_OFS_SUMHI: sumhi_q <= reg_wdata_i;
                `VDRC_OFS_SUMLO: sumlo_q <= reg_wdata_i;
                `VDRC_OFS_SPI: spi_q <= {4'h0, reg_wdata_i[3:0]};
                `VDRC_OFS_VADJ: vadj_q <= reg_wdata_i;
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------
    // Unmapped offsets answer zero; a read always answers next cycle.
    always_ff @(posedge sys_clk_i or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            reg_rdata_o <= 8'h00;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_rd_i;
            if (reg_rd_i) begin
                case (reg_addr_i)
                    `VDRC_OFS_INFMT: reg_rdata_o <= infmt_q;
                    `VDRC_OFS_POTYPE: reg_rdata_o <= potype_q;
                    `VDRC_OFS_POCTRL: reg_rdata_o <= poctrl_q;
                    `VDRC_OFS_TXSEL: reg_rdata_o <= txsel_q;
                    `VDRC_OFS_ENCSEL: reg_rdata_o <= encsel_q;
                    `VDRC_OFS_SCLSEL: reg_rdata_o <= sclsel_q;
                    `VDRC_OFS_CNVSEL: reg_rdata_o <= cnvsel_q;
                    `VDRC_OFS_CHCTRL: reg_rdata_o <= chctrl_q;
                    `VDRC_OFS_AUDSEL: reg_rdata_o <= audsel_q;
                    `VDRC_OFS_HPSSEL: reg_rdata_o <= hpssel_q;
                    `VDRC_OFS_DITH: reg_rdata_o <= dith_q;
                    `VDRC_OFS_PIXHI: reg_rdata_o <= pixhi_q;
                    `VDRC_OFS_PIXLO: reg_rdata_o <= pixlo_q;
                    `VDRC_OFS_SUMHI: reg_rdata_o <= sumhi_q;
                    `VDRC_OFS_SUMLO: reg_rdata_o <= sumlo_q;
                    `VDRC_OFS_SPI: reg_rdata_o <= spi_q;
                    `VDRC_OFS_VADJ: reg_rdata_o <= vadj_q;
                    default: reg_rdata_o <= 8'h00;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Input formatting and channel selection
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            input_format_code_o <= `VDRC_RST_INFMT;
            prim_chan_o <= '0;
            sec_chan_o <= '0;
            rx_proc_bypass_o <= 1'b0;
        end else begin
            input_format_code_o <= infmt_q;
            prim_chan_o <= chan_check(chctrl_q[1:0], `VDRC_MAX_PCHAN);
            sec_chan_o <= chan_check(chctrl_q[3:2], `VDRC_MAX_SCHAN);
            rx_proc_bypass_o <= chctrl_q[`VDRC_BIT_BYPASS];
        end
    end

    // ------------------------------------------------------------------
    // Parallel output
    // ------------------------------------------------------------------
    logic [3:0] pofmt;
    logic pofmt_ok;

    assign pofmt = poctrl_q[7:4];
    assign pofmt_ok = (pofmt >= `VDRC_FMT_MIN) && (pofmt <= `VDRC_FMT_MAX);

    // Width index 0/1/2 means 8/10/12 bits per bus.
    always_ff @(posedge sys_clk_i or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            parallel_out_bus_format_o <= '0;
            parallel_out_source_o <= '0;
        end else begin
            parallel_out_bus_format_o.valid <= pofmt_ok;
            parallel_out_bus_format_o.three_bus <= pofmt >= `VDRC_FMT_3BUS;
            if (!pofmt_ok) begin
                parallel_out_bus_format_o.width_idx <= 2'h0;
            end else if (pofmt >= `VDRC_FMT_3BUS) begin
                parallel_out_bus_format_o.width_idx <= 2'(pofmt - `VDRC_FMT_3BUS);
            end else begin
                parallel_out_bus_format_o.width_idx <= 2'(pofmt - `VDRC_FMT_MIN);
            end
            parallel_out_bus_format_o.pseudo_444 <= potype_q[`VDRC_BIT_PSEUDO];
            // An unusable format keeps the output quiet whatever the enable
            parallel_out_bus_format_o.enable <= poctrl_q[`VDRC_BIT_POEN] && pofmt_ok;
            parallel_out_source_o <= src_check({1'b0, poctrl_q[2:0]}, `VDRC_MAX_OUTSRC);
        end
    end

    // ------------------------------------------------------------------
    // Transmitters and encoders
    // ------------------------------------------------------------------
    logic gate_sd_hd;

    assign gate_sd_hd = chctrl_q[`VDRC_BIT_GATE];

    // Software keeps the two encoder fields equal in SD-only mode unless
    // it sets the gating bit, which makes the copy in hardware.
    always_ff @(posedge sys_clk_i or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            transmitter1_source_o <= '0;
            transmitter2_source_o <= '0;
            high_def_encoder_source_o <= '0;
            std_def_encoder_source_o <= '0;
        end else begin
            transmitter1_source_o <= src_check(txsel_q[7:4], `VDRC_MAX_OUTSRC);
            transmitter2_source_o <= src_check(txsel_q[3:0], `VDRC_MAX_OUTSRC);
            std_def_encoder_source_o <= src_check(encsel_q[3:0], `VDRC_MAX_OUTSRC);
            if (gate_sd_hd) begin
                high_def_encoder_source_o <= src_check(encsel_q[3:0], `VDRC_MAX_OUTSRC);
            end else begin
                high_def_encoder_source_o <= src_check(encsel_q[7:4], `VDRC_MAX_OUTSRC);
            end
        end
    end

    // ------------------------------------------------------------------
    // Processing engines
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            prim_scaler_engine_source_o <= '0;
            sec_scaler_engine_source_o <= '0;
            interlacer_source_o <= '0;
            blend1_source_o <= '0;
            blend2_source_o <= '0;
            prescaler_source_o <= '0;
        end else begin
            sec_scaler_engine_source_o <= src_check(sclsel_q[7:4], `VDRC_MAX_SSCL);
            prim_scaler_engine_source_o <= src_check(sclsel_q[3:0], `VDRC_MAX_PSCL);
            interlacer_source_o <= src_check(cnvsel_q[7:4], `VDRC_MAX_CNV);
            blend1_source_o <= src_check(cnvsel_q[3:0], `VDRC_MAX_BLEND);
            blend2_source_o <= src_check(audsel_q[3:0], `VDRC_MAX_BLEND);
            prescaler_source_o <= src_check(hpssel_q[7:4], `VDRC_MAX_HPS);
        end
    end

    // ------------------------------------------------------------------
    // Audio, dither and serial port clocking
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            audio_mode_o <= '0;
            dither_o <= '0;
            spi_clocking_o <= '0;
        end else begin
            audio_mode_o.dual <= audsel_q[7:6] != 2'h0;
            audio_mode_o.tx1_spdif <= audsel_q[7];
            audio_mode_o.tx2_spdif <= audsel_q[7:6] == 2'h1 || audsel_q[7:6] == 2'h3;
            dither_o.level <= dith_q[5:4];
            dither_o.alpha <= dith_q[3:0];
            dither_o.pixel_thr <= {pixhi_q[3:0], pixlo_q};
            dither_o.sum_thr <= {sumhi_q, sumlo_q};
            spi_clocking_o.slave_cpol <= spi_q[`VDRC_BIT_SCPOL];
            spi_clocking_o.slave_cpha <= spi_q[`VDRC_BIT_SCPHA];
            spi_clocking_o.master_cpol <= spi_q[`VDRC_BIT_MCPOL];
            spi_clocking_o.master_cpha <= spi_q[`VDRC_BIT_MCPHA];
        end
    end

    // ------------------------------------------------------------------
    // Video adjust enables
    // ------------------------------------------------------------------
    vdrc_adj_t adj_staged;
    vdrc_adj_t adj_applied;

    assign adj_staged.saturation_en = vadj_q[`VDRC_BIT_SATEN];
    assign adj_staged.brightness_en = vadj_q[`VDRC_BIT_BRTEN];

    vdrc_adj_buffer u_adj_buffer (
        .clk_i(sys_clk_i),
        .rst_n_i(rst_sync_q),
        .dbuf_i(vadj_q[`VDRC_BIT_DBUF]),
        .vblank_i(vblank_i),
        .staged_i(adj_staged),
        .applied_o(adj_applied)
    );

    // Extra stage so the top output comes straight from a flip-flop.
    always_ff @(posedge sys_clk_i or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            video_adjust_o <= '0;
        end else begin
            video_adjust_o <= adj_applied;
        end
    end

endmodule

// ### inc/vdrc_defs.svh
/*
 * Register offsets, field positions, reset values and code limits of the
 * video datapath routing control bank.
 * Assumes a 16-bit register address and 8-bit register data.
 */
`ifndef VDRC_DEFS_SVH
`define VDRC_DEFS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define VDRC_OFS_INFMT 16'h1A00
`define VDRC_OFS_POTYPE 16'h1A01
`define VDRC_OFS_POCTRL 16'h1A02
`define VDRC_OFS_TXSEL 16'h1A03
`define VDRC_OFS_ENCSEL 16'h1A04
`define VDRC_OFS_SCLSEL 16'h1A05
`define VDRC_OFS_CNVSEL 16'h1A06
`define VDRC_OFS_CHCTRL 16'h1A07
`define VDRC_OFS_AUDSEL 16'h1A08
`define VDRC_OFS_HPSSEL 16'h1A09
`define VDRC_OFS_DITH 16'h1A0D
`define VDRC_OFS_PIXHI 16'h1A0E
`define VDRC_OFS_PIXLO 16'h1A0F
`define VDRC_OFS_SUMHI 16'h1A10
`define VDRC_OFS_SUMLO 16'h1A11
`define VDRC_OFS_SPI 16'h1A14
`define VDRC_OFS_VADJ 16'h1A24

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define VDRC_RST_INFMT 8'hFE
`define VDRC_RST_POTYPE 8'h02
`define VDRC_RST_POCTRL 8'h70
`define VDRC_RST_TXSEL 8'h00
`define VDRC_RST_ENCSEL 8'h00
`define VDRC_RST_SCLSEL 8'h00
`define VDRC_RST_CNVSEL 8'h00
`define VDRC_RST_CHCTRL 8'h64
`define VDRC_RST_AUDSEL 8'h00
`define VDRC_RST_HPSSEL 8'h00
`define VDRC_RST_DITH 8'h28
`define VDRC_RST_PIXHI 8'h00
`define VDRC_RST_PIXLO 8'h32
`define VDRC_RST_SUMHI 8'h00
`define VDRC_RST_SUMLO 8'h64
`define VDRC_RST_SPI 8'h0C
`define VDRC_RST_VADJ 8'h81

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define VDRC_BIT_PSEUDO 0
`define VDRC_BIT_POEN 3
`define VDRC_BIT_BYPASS 7
`define VDRC_BIT_GATE 6
`define VDRC_BIT_SCPOL 3
`define VDRC_BIT_SCPHA 2
`define VDRC_BIT_MCPOL 1
`define VDRC_BIT_MCPHA 0
`define VDRC_BIT_DBUF 7
`define VDRC_BIT_SATEN 6
`define VDRC_BIT_BRTEN 5

// ----------------------------------------------------------------------
// Highest legal code of each source encoding; output format range and first three-bus code
// ----------------------------------------------------------------------
`define VDRC_MAX_OUTSRC 4'h7
`define VDRC_MAX_SSCL 4'h6
`define VDRC_MAX_PSCL 4'h5
`define VDRC_MAX_CNV 4'h4
`define VDRC_MAX_BLEND 4'h4
`define VDRC_MAX_HPS 4'h3
`define VDRC_MAX_SCHAN 2'h2
`define VDRC_MAX_PCHAN 2'h2
`define VDRC_FMT_MIN 4'h3
`define VDRC_FMT_MAX 4'h8
`define VDRC_FMT_3BUS 4'h6

`endif

// ### inc/vdrc_pkg.sv
/*
 * Types shared by the video datapath routing control bank.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package vdrc_pkg;

    // Source selection handed to a consumer; valid low parks the consumer
    typedef struct packed {
        logic valid;
        logic [3:0] code;
    } vdrc_src_t;

    typedef struct packed {
        logic valid;
        logic [1:0] code;
    } vdrc_chan_t;

    // Parallel output bus arrangement
    typedef struct packed {
        logic valid;
        logic three_bus;
        logic [1:0] width_idx;
        logic pseudo_444;
        logic enable;
    } vdrc_pofmt_t;

    typedef struct packed {
        logic slave_cpol;
        logic slave_cpha;
        logic master_cpol;
        logic master_cpha;
    } vdrc_spi_t;

    typedef struct packed {
        logic [1:0] level;
        logic [3:0] alpha;
        logic [11:0] pixel_thr;
        logic [15:0] sum_thr;
    } vdrc_dither_t;

    typedef struct packed {
        logic dual;
        logic tx1_spdif;
        logic tx2_spdif;
    } vdrc_audio_t;

    typedef struct packed {
        logic saturation_en;
        logic brightness_en;
    } vdrc_adj_t;

endpackage

// ### hdl/vdrc_adj_buffer.sv
/*
 * Holding stage for the video-adjust enables.
 * Assumes vblank_i comes from timing logic on the same clock.
 */
`timescale 1ns/100ps

module vdrc_adj_buffer
    import vdrc_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Control
    input wire logic dbuf_i,
    input wire logic vblank_i,
    input wire vdrc_adj_t staged_i,
    // Applied values
    output vdrc_adj_t applied_o
);

    vdrc_adj_t applied_q;

    // ------------------------------------------------------------------
    // Transfer
    // ------------------------------------------------------------------
    // Staged values follow writes; in buffered mode they only reach the
    // video path inside the blanking interval so a frame never changes
    // mid-picture.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            applied_q <= '0;
        end else if (!dbuf_i || vblank_i) begin
            applied_q <= staged_i;
        end
    end

    assign applied_o = applied_q;

endmodule

// ### tb/vdrc_checker.sv
/* Checker: nine decoded outputs against the write that set them.
   Assumes a bind into vdrc_top, seeing only its ports. */
`timescale 1ns/100ps
`include "vdrc_defs.svh"
module vdrc_checker
    import vdrc_pkg::*;
(
    // Clock, reset and host writes
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic reg_wr_i,
    input wire logic [15:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    // Decoded outputs
    input wire vdrc_src_t transmitter2_source_o,
    input wire vdrc_src_t prim_scaler_engine_source_o,
    input wire vdrc_src_t interlacer_source_o,
    input wire vdrc_src_t prescaler_source_o,
    input wire vdrc_spi_t spi_clocking_o,
    input wire vdrc_pofmt_t parallel_out_bus_format_o,
    input wire vdrc_audio_t audio_mode_o,
    input wire vdrc_chan_t prim_chan_o,
    input wire logic rx_proc_bypass_o
);
    // ------------------------------------------------------------
    // Write history, two edges deep to match the decode latency
    // ------------------------------------------------------------
    logic [1:0] v_q;
    logic [15:0] a1_q, a2_q;
    logic [7:0] w1_q, w2_q;
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            v_q <= 2'h0;
        end else begin
            v_q <= {v_q[0], reg_wr_i};
        end
    end
    always_ff @(posedge sys_clk_i) begin
        a1_q <= reg_addr_i;
        a2_q <= a1_q;
        w1_q <= reg_wdata_i;
        w2_q <= w1_q;
    end
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    a_tx2_route: assert property (v_q[1] && a2_q == `VDRC_OFS_TXSEL |->
        transmitter2_source_o == {w2_q[3:0] < 4'h8, w2_q[3:0] < 4'h8 ? w2_q[3:0] : 4'h0})
        else $error("tx2 source wrong");
    a_pscl_route: assert property (v_q[1] && a2_q == `VDRC_OFS_SCLSEL |->
        prim_scaler_engine_source_o == {w2_q[3:0] < 4'h6, w2_q[3:0] < 4'h6 ? w2_q[3:0] : 4'h0})
        else $error("primary scaler source wrong");
    a_cnv_route: assert property (v_q[1] && a2_q == `VDRC_OFS_CNVSEL |->
        interlacer_source_o == {w2_q[7:4] < 4'h5, w2_q[7:4] < 4'h5 ? w2_q[7:4] : 4'h0})
        else $error("interlacer source wrong");
    a_hps_route: assert property (v_q[1] && a2_q == `VDRC_OFS_HPSSEL |->
        prescaler_source_o == {w2_q[7:4] < 4'h4, w2_q[7:4] < 4'h4 ? w2_q[7:4] : 4'h0})
        else $error("prescaler source wrong");
    a_spi_bits: assert property (v_q[1] && a2_q == `VDRC_OFS_SPI |->
        spi_clocking_o == w2_q[3:0]) else $error("serial clocking wrong");
    a_out_enable: assert property (v_q[1] && a2_q == `VDRC_OFS_POCTRL |->
        parallel_out_bus_format_o.enable == (w2_q[3] && w2_q[7:4] inside {[4'h3:4'h8]}))
        else $error("output enable wrong");
    a_audio_map: assert property (v_q[1] && a2_q == `VDRC_OFS_AUDSEL |->
        audio_mode_o == {|w2_q[7:6], w2_q[7:6]}) else $error("audio mode wrong");
    a_chan_sel: assert property (v_q[1] && a2_q == `VDRC_OFS_CHCTRL |->
        prim_chan_o.valid == (w2_q[1:0] != 2'h3) && rx_proc_bypass_o == w2_q[7])
        else $error("channel select wrong");
endmodule
bind vdrc_top vdrc_checker chk_u (.sys_clk_i, .rst_n_i, .reg_wr_i, .reg_addr_i, .reg_wdata_i,
    .transmitter2_source_o, .prim_scaler_engine_source_o, .interlacer_source_o,
    .prescaler_source_o, .spi_clocking_o, .parallel_out_bus_format_o, .audio_mode_o,
    .prim_chan_o, .rx_proc_bypass_o);

// ### tb/vdrc_top_test.sv
/* Self-checking bench for the routing bank.
   Assumes the host port contract of vdrc_top and a 100 MHz clock. */
`timescale 1ns/100ps
`include "vdrc_defs.svh"
module vdrc_top_test;
    import vdrc_pkg::*;
    logic sys_clk_i, rst_n_i, reg_wr_i, reg_rd_i, vblank_i, reg_rvalid_o, rx_proc_bypass_o;
    logic [15:0] reg_addr_i;
    logic [7:0] reg_wdata_i, reg_rdata_o, input_format_code_o;
    vdrc_chan_t prim_chan_o, sec_chan_o;
    vdrc_pofmt_t parallel_out_bus_format_o;
    vdrc_src_t parallel_out_source_o, transmitter1_source_o, transmitter2_source_o,
        high_def_encoder_source_o, std_def_encoder_source_o, prim_scaler_engine_source_o,
        sec_scaler_engine_source_o, interlacer_source_o, blend1_source_o, blend2_source_o,
        prescaler_source_o;
    vdrc_audio_t audio_mode_o;
    vdrc_dither_t dither_o;
    vdrc_spi_t spi_clocking_o;
    vdrc_adj_t video_adjust_o;
    int bad_count, n_tests;
    // Offset low byte and reset value of every mapped register
    localparam logic [15:0] RV [17] = '{16'h00FE, 16'h0102, 16'h0270, 16'h0300, 16'h0400,
        16'h0500, 16'h0600, 16'h0764, 16'h0800, 16'h0900, 16'h0D28, 16'h0E00, 16'h0F32,
        16'h1000, 16'h1164, 16'h140C, 16'h2481};
    localparam logic [7:0] WA [8] = '{8'h03, 8'h05, 8'h06, 8'h08, 8'h09, 8'h14, 8'h02, 8'h07};
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin bad_count++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, a, b); end end
    vdrc_top dut_u (.*);
    initial begin
        sys_clk_i = 1'h0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end
    task automatic idle(input int n);
        reg_wr_i = 1'h0;
        reg_rd_i = 1'h0;
        repeat (n) begin
            @(posedge sys_clk_i);
            #1;
        end
    endtask
    // Strobes stay up between calls so back-to-back transfers need no gap
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        reg_rd_i = 1'h0;
        reg_wr_i = 1'h1;
        reg_addr_i = a;
        reg_wdata_i = d;
        @(posedge sys_clk_i);
        #1;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        reg_wr_i = 1'h0;
        reg_rd_i = 1'h1;
        reg_addr_i = a;
        @(posedge sys_clk_i);
        #1;
        `CHK({reg_rvalid_o, reg_rdata_o}, {1'h1, e})
    endtask
    function automatic logic [4:0] exp_src(input logic [3:0] c, input logic [3:0] m);
        return {c <= m, c <= m ? c : 4'h0};
    endfunction
    task automatic t_reset;
        foreach (RV[k]) rd({8'h1A, RV[k][15:8]}, RV[k][7:0]);
        rd(16'h1A0A, 8'h00);
        `CHK(spi_clocking_o, 4'hC)
        `CHK(parallel_out_bus_format_o, 6'h34)
        `CHK(input_format_code_o, 8'hFE)
    endtask
    task automatic t_codes;
        logic [3:0] c;
        for (int i = 0; i < 16; i++) begin
            c = i[3:0];
            foreach (WA[k]) wr({8'h1A, WA[k]}, {c, ~c});
            idle(1);
            `CHK(transmitter1_source_o, exp_src(c, 4'h7))
            `CHK(sec_scaler_engine_source_o, exp_src(c, 4'h6))
            `CHK(blend1_source_o, exp_src(~c, 4'h4))
            `CHK(blend2_source_o, exp_src(~c, 4'h4))
            `CHK(sec_chan_o, {|c[3:2], {2{|c[3:2]}} & ~c[3:2]})
            `CHK(parallel_out_source_o, {2'h2, ~c[2:0]})
        end
    endtask
    task automatic t_pofmt;
        wr(`VDRC_OFS_POTYPE, 8'hFF);
        wr(`VDRC_OFS_POCTRL, 8'h8B);
        rd(`VDRC_OFS_POTYPE, 8'h01);
        `CHK(parallel_out_bus_format_o, 6'h3B)
        wr(`VDRC_OFS_POCTRL, 8'h38);
        idle(2);
        `CHK(parallel_out_bus_format_o, 6'h23)
        wr(`VDRC_OFS_POCTRL, 8'h98);
        idle(2);
        `CHK(parallel_out_bus_format_o, 6'h12)
    endtask
    task automatic t_misc;
        wr(`VDRC_OFS_ENCSEL, 8'h25);
        wr(`VDRC_OFS_CHCTRL, 8'h40);
        wr(`VDRC_OFS_DITH, 8'hFB);
        wr(`VDRC_OFS_PIXHI, 8'hA5);
        wr(`VDRC_OFS_PIXLO, 8'h5A);
        wr(`VDRC_OFS_SUMHI, 8'hC3);
        wr(`VDRC_OFS_SUMLO, 8'h3C);
        wr(`VDRC_OFS_VADJ, 8'hC0);
        `CHK(high_def_encoder_source_o, 5'h15)
        wr(`VDRC_OFS_CHCTRL, 8'h00);
        idle(4);
        `CHK(high_def_encoder_source_o, 5'h12)
        `CHK(std_def_encoder_source_o, 5'h15)
        `CHK(dither_o, {2'h3, 4'hB, 12'h55A, 16'hC33C})
        `CHK(video_adjust_o, 2'h0)
        vblank_i = 1'h1;
        idle(3);
        `CHK(video_adjust_o, 2'h2)
        vblank_i = 1'h0;
        wr(`VDRC_OFS_VADJ, 8'h20);
        idle(3);
        `CHK(video_adjust_o, 2'h1)
    endtask
    task automatic wrap_up;
        if (bad_count == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        #20000;
        bad_count++;
        wrap_up;
    end
    initial begin
        {rst_n_i, reg_wr_i, reg_rd_i, vblank_i, reg_addr_i, reg_wdata_i} = '0;
        repeat (3) @(posedge sys_clk_i);
        #1;
        rst_n_i = 1'h1;
        idle(3);
        t_reset;
        t_codes;
        t_pofmt;
        t_misc;
        wrap_up;
    end
endmodule
